// *** rtl/axi_fabric_cfg.svh ***
`ifndef AXI_FABRIC_CFG_SVH
`define AXI_FABRIC_CFG_SVH

// ********************************************************************
// bus geometry
// ********************************************************************
`define AXI_DW 64
`define AXI_SW 8
`define AXI_AW 32
`define AXI_IDW 4
`define AXI_LENW 4
`define AXI_SZW 3

// ********************************************************************
// encodings
// ********************************************************************
`define SIZE_2B 3'h1
`define SIZE_4B 3'h2
`define SIZE_8B 3'h3
`define BURST_INCR 2'h1
`define RESP_OKAY 2'h0
`define STRB_ALL 8'hFF
`define ADDR_ONE 32'h1

// ********************************************************************
// buffering and local memory
// ********************************************************************
`define WFIFO_DEPTH 8
`define MEM_AW 8
`define MEM_LSB 3

`endif

// *** rtl/axi_fabric_master_slave_interface.sv ***
// Behaviour
// R1: master holds write address and control until AWREADY.
// R2: master holds each write beat until WREADY.
// R3: next write beat appears only after the previous was accepted.
// R4: WLAST high on the final write beat only.
// R5: master raises BREADY and compares returned BID with issued id.
// R6: read address carries burst length and incrementing burst type.
// R7: master holds read address and control until ARREADY.
// R8: master raises RREADY while able to take read beats.
// R9: RLAST marks final read beat; master read machine returns idle.
// R10: slave waits for AWVALID, takes address, acknowledges with AWREADY.
// R11: slave then acknowledges each WVALID beat with WREADY.
// R12: slave keeps taking write beats until the WLAST beat.
// R13: slave holds BVALID with matching id until BREADY.
// R14: slave waits ARVALID, captures address, acknowledges with ARREADY.
// R15: slave fetches local data and marks each beat with RVALID.
// R16: slave advances read beat only after RREADY.
// R17: slave raises RLAST on the last read beat.
// R18: slave accepts only two, four or eight byte size codes.
// R19: master data path is 64 bits wide.
// R20: no unaligned, out-of-order or low-power handling.
// R21: slave makes memory write and read strobes with addresses.
// R22: bursts increment the address by the transfer size per beat.
// R23: slave response id equals the answered write id.
// R24: under reset all valid outputs low, machines idle; BREADY, RREADY and slave WREADY are low, slave AWREADY and ARREADY follow the size check.
`timescale 1ns/100ps
`include "axi_fabric_cfg.svh"

// ********************************************************************
// write data buffer
// ********************************************************************
module wdata_fifo #(
  parameter int WIDTH = `AXI_DW,
  parameter int DEPTH = `WFIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  // full and empty come straight from the occupancy count
  assign in_ready = (count_reg != DEPTH[PW:0]);
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  // storage has no reset; only pointers and count carry state
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers wrap naturally since the depth is a power of two
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : wdata_fifo

// ********************************************************************
// fabric master and slave
// ********************************************************************
module axi_fabric_master_slave_interface
  import axi_fabric_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // user write request and data
  input wire burst_req_t WR_CMD,
  input wire logic WR_CMD_VALID,
  output logic WR_CMD_READY,
  input wire logic [`AXI_DW-1:0] WR_DATA,
  input wire logic WR_DATA_VALID,
  output logic WR_DATA_READY,
  output logic WR_DONE,
  output logic WR_ID_ERR,
  output logic [1:0] WR_RESP,
  // user read request and data
  input wire burst_req_t RD_CMD,
  input wire logic RD_CMD_VALID,
  output logic RD_CMD_READY,
  output logic [`AXI_DW-1:0] RD_DATA,
  output logic RD_DATA_VALID,
  output logic RD_DATA_LAST,
  // master write address channel
  output logic [`AXI_IDW-1:0] M_AWID,
  output logic [`AXI_AW-1:0] M_AWADDR,
  output logic [`AXI_LENW-1:0] M_AWLEN,
  output logic [`AXI_SZW-1:0] M_AWSIZE,
  output logic [1:0] M_AWBURST,
  output logic M_AWVALID,
  input wire logic M_AWREADY,
  // master write data and response channels
  output logic [`AXI_DW-1:0] M_WDATA,
  output logic [`AXI_SW-1:0] M_WSTRB,
  output logic M_WLAST,
  output logic M_WVALID,
  input wire logic M_WREADY,
  input wire logic [`AXI_IDW-1:0] M_BID,
  input wire logic [1:0] M_BRESP,
  input wire logic M_BVALID,
  output logic M_BREADY,
  // master read channels
  output logic [`AXI_IDW-1:0] M_ARID,
  output logic [`AXI_AW-1:0] M_ARADDR,
  output logic [`AXI_LENW-1:0] M_ARLEN,
  output logic [`AXI_SZW-1:0] M_ARSIZE,
  output logic [1:0] M_ARBURST,
  output logic M_ARVALID,
  input wire logic M_ARREADY,
  input wire logic [`AXI_DW-1:0] M_RDATA,
  input wire logic M_RLAST,
  input wire logic M_RVALID,
  output logic M_RREADY,
  // slave write channels
  input wire logic [`AXI_IDW-1:0] S_AWID,
  input wire logic [`AXI_AW-1:0] S_AWADDR,
  input wire logic [`AXI_SZW-1:0] S_AWSIZE,
  input wire logic S_AWVALID,
  output logic S_AWREADY,
  input wire logic [`AXI_DW-1:0] S_WDATA,
  input wire logic [`AXI_SW-1:0] S_WSTRB,
  input wire logic S_WLAST,
  input wire logic S_WVALID,
  output logic S_WREADY,
  output logic [`AXI_IDW-1:0] S_BID,
  output logic [1:0] S_BRESP,
  output logic S_BVALID,
  input wire logic S_BREADY,
  // slave read channels
  input wire logic [`AXI_IDW-1:0] S_ARID,
  input wire logic [`AXI_AW-1:0] S_ARADDR,
  input wire logic [`AXI_LENW-1:0] S_ARLEN,
  input wire logic [`AXI_SZW-1:0] S_ARSIZE,
  input wire logic S_ARVALID,
  output logic S_ARREADY,
  output logic [`AXI_IDW-1:0] S_RID,
  output logic [`AXI_DW-1:0] S_RDATA,
  output logic [1:0] S_RRESP,
  output logic S_RLAST,
  output logic S_RVALID,
  input wire logic S_RREADY
);

  // ******************************************************************
  // helpers
  // ******************************************************************
  // only two, four and eight byte transfers are served
  function automatic logic size_ok(input logic [`AXI_SZW-1:0] sz);
    return (sz == `SIZE_2B) || (sz == `SIZE_4B) || (sz == `SIZE_8B);
  endfunction : size_ok

  function automatic logic [`AXI_AW-1:0] next_addr(
    input logic [`AXI_AW-1:0] a, input logic [`AXI_SZW-1:0] sz);
    return a + (`ADDR_ONE << sz);
  endfunction : next_addr

  function automatic logic [`MEM_AW-1:0] mem_index(
    input logic [`AXI_AW-1:0] a);
    return a[`MEM_LSB +: `MEM_AW]; // R20
  endfunction : mem_index

  // ******************************************************************
  // master write path
  // ******************************************************************
  mw_state_t mw_state_reg;
  burst_req_t aw_reg;
  logic [`AXI_LENW-1:0] wcnt_reg;
  logic fifo_valid;
  logic w_fire;

  // the buffer stalls the user only once all eight entries hold unsent beats
  wdata_fifo #(.WIDTH(`AXI_DW), .DEPTH(`WFIFO_DEPTH)) u_wfifo (
    .clk(CLK),
    .rst_n(RST_N),
    .in_valid(WR_DATA_VALID),
    .in_ready(WR_DATA_READY),
    .in_data(WR_DATA),
    .out_valid(fifo_valid),
    .out_ready(w_fire),
    .out_data(M_WDATA)
  );

  assign WR_CMD_READY = (mw_state_reg == MW_IDLE);
  assign M_AWVALID = (mw_state_reg == MW_ADDR); // R1
  assign M_AWID = aw_reg.id;
  assign M_AWADDR = aw_reg.addr;
  assign M_AWLEN = aw_reg.len;
  assign M_AWSIZE = aw_reg.size;
  assign M_AWBURST = `BURST_INCR; // R22
  // the head of the buffer only pops on acceptance, so a beat holds
  assign M_WVALID = (mw_state_reg == MW_DATA) && fifo_valid; // R2 R3
  assign w_fire = M_WVALID && M_WREADY;
  assign M_WLAST = (wcnt_reg == aw_reg.len); // R4
  assign M_WSTRB = `STRB_ALL; // R19
  assign M_BREADY = (mw_state_reg == MW_RESP); // R5

  // write sequencing: address, beats, response
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mw_state_reg <= MW_IDLE; // R24
      aw_reg <= '0;
      wcnt_reg <= '0;
    end else begin
      case (mw_state_reg)
        MW_IDLE: begin
          if (WR_CMD_VALID) begin
            aw_reg <= WR_CMD;
            mw_state_reg <= MW_ADDR;
          end
        end
        MW_ADDR: begin
          wcnt_reg <= '0;
          if (M_AWREADY) begin
            mw_state_reg <= MW_DATA; // R1
          end
        end
        MW_DATA: begin
          if (w_fire) begin
            wcnt_reg <= wcnt_reg + 1'b1; // R3
            if (M_WLAST) begin
              mw_state_reg <= MW_RESP;
            end
          end
        end
        MW_RESP: begin
          if (M_BVALID) begin
            mw_state_reg <= MW_IDLE;
          end
        end
        default: mw_state_reg <= MW_IDLE;
      endcase
    end
  end

  // completion report with id check
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      WR_DONE <= 1'b0;
      WR_ID_ERR <= 1'b0;
      WR_RESP <= `RESP_OKAY;
    end else begin
      WR_DONE <= M_BVALID && M_BREADY;
      if (M_BVALID && M_BREADY) begin
        WR_ID_ERR <= (M_BID != aw_reg.id); // R5
        WR_RESP <= M_BRESP;
      end
    end
  end

  // ******************************************************************
  // master read path
  // ******************************************************************
  mr_state_t mr_state_reg;
  burst_req_t ar_reg;

  assign RD_CMD_READY = (mr_state_reg == MR_IDLE);
  assign M_ARVALID = (mr_state_reg == MR_ADDR); // R7
  assign M_ARID = ar_reg.id;
  assign M_ARADDR = ar_reg.addr;
  assign M_ARLEN = ar_reg.len; // R6
  assign M_ARSIZE = ar_reg.size;
  assign M_ARBURST = `BURST_INCR; // R6
  assign M_RREADY = (mr_state_reg == MR_DATA); // R8

  // read sequencing; the user side must take every beat as it comes
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mr_state_reg <= MR_IDLE; // R24
      ar_reg <= '0;
    end else begin
      case (mr_state_reg)
        MR_IDLE: begin
          if (RD_CMD_VALID) begin
            ar_reg <= RD_CMD;
            mr_state_reg <= MR_ADDR;
          end
        end
        MR_ADDR: begin
          if (M_ARREADY) begin
            mr_state_reg <= MR_DATA;
          end
        end
        MR_DATA: begin
          if (M_RVALID && M_RLAST) begin
            mr_state_reg <= MR_IDLE; // R9
          end
        end
        default: mr_state_reg <= MR_IDLE;
      endcase
    end
  end

  // returned beats are registered toward the user
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RD_DATA <= '0;
      RD_DATA_VALID <= 1'b0;
      RD_DATA_LAST <= 1'b0;
    end else begin
      RD_DATA_VALID <= M_RVALID && M_RREADY;
      RD_DATA_LAST <= M_RVALID && M_RREADY && M_RLAST;
      if (M_RVALID && M_RREADY) begin
        RD_DATA <= M_RDATA;
      end
    end
  end

  // ******************************************************************
  // slave local memory
  // ******************************************************************
  logic [`AXI_DW-1:0] mem_reg [2**`MEM_AW];
  logic mem_we;
  logic mem_re;
  logic [`MEM_AW-1:0] mem_waddr;
  logic [`MEM_AW-1:0] mem_raddr;

  // ******************************************************************
  // slave write path
  // ******************************************************************
  sw_state_t sw_state_reg;
  logic [`AXI_IDW-1:0] sw_id_reg;
  logic [`AXI_AW-1:0] sw_addr_reg;
  logic [`AXI_SZW-1:0] sw_size_reg;

  // an unsupported size is never acknowledged
  assign S_AWREADY = (sw_state_reg == SW_IDLE) && size_ok(S_AWSIZE); // R10 R18
  assign S_WREADY = (sw_state_reg == SW_DATA); // R11
  assign S_BVALID = (sw_state_reg == SW_RESP); // R13
  assign S_BID = sw_id_reg; // R23
  assign S_BRESP = `RESP_OKAY;
  assign mem_we = S_WVALID && S_WREADY; // R21
  assign mem_waddr = mem_index(sw_addr_reg);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sw_state_reg <= SW_IDLE; // R24
      sw_id_reg <= '0;
      sw_addr_reg <= '0;
      sw_size_reg <= '0;
    end else begin
      case (sw_state_reg)
        SW_IDLE: begin
          if (S_AWVALID && S_AWREADY) begin
            sw_id_reg <= S_AWID; // R23
            sw_addr_reg <= S_AWADDR;
            sw_size_reg <= S_AWSIZE;
            sw_state_reg <= SW_DATA; // R10
          end
        end
        SW_DATA: begin
          if (mem_we) begin
            sw_addr_reg <= next_addr(sw_addr_reg, sw_size_reg); // R22
            if (S_WLAST) begin
              sw_state_reg <= SW_RESP; // R12
            end
          end
        end
        SW_RESP: begin
          if (S_BREADY) begin
            sw_state_reg <= SW_IDLE; // R13
          end
        end
        default: sw_state_reg <= SW_IDLE;
      endcase
    end
  end

  // byte lanes follow the strobes, so narrow beats share a word
  always_ff @(posedge CLK) begin
    if (mem_we) begin
      for (int b = 0; b < `AXI_SW; b++) begin
        if (S_WSTRB[b]) begin
          mem_reg[mem_waddr][b*8 +: 8] <= S_WDATA[b*8 +: 8]; // R21
        end
      end
    end
  end

  // ******************************************************************
  // slave read path
  // ******************************************************************
  sr_state_t sr_state_reg;
  logic [`AXI_IDW-1:0] sr_id_reg;
  logic [`AXI_AW-1:0] sr_addr_reg;
  logic [`AXI_LENW-1:0] sr_len_reg;
  logic [`AXI_SZW-1:0] sr_size_reg;
  logic [`AXI_LENW-1:0] sr_cnt_reg;
  logic [`AXI_DW-1:0] rdata_reg;

  assign S_ARREADY = (sr_state_reg == SR_IDLE) && size_ok(S_ARSIZE); // R14
  assign S_RVALID = (sr_state_reg == SR_SEND); // R15
  assign S_RLAST = S_RVALID && (sr_cnt_reg == sr_len_reg); // R17
  assign S_RID = sr_id_reg;
  assign S_RRESP = `RESP_OKAY;
  assign S_RDATA = rdata_reg;
  assign mem_re = (sr_state_reg == SR_FETCH); // R21
  assign mem_raddr = mem_index(sr_addr_reg);

  // one fetch cycle per beat trades throughput for a plain memory
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sr_state_reg <= SR_IDLE; // R24
      sr_id_reg <= '0;
      sr_addr_reg <= '0;
      sr_len_reg <= '0;
      sr_size_reg <= '0;
      sr_cnt_reg <= '0;
    end else begin
      case (sr_state_reg)
        SR_IDLE: begin
          if (S_ARVALID && S_ARREADY) begin
            sr_id_reg <= S_ARID; // R14
            sr_addr_reg <= S_ARADDR;
            sr_len_reg <= S_ARLEN;
            sr_size_reg <= S_ARSIZE;
            sr_cnt_reg <= '0;
            sr_state_reg <= SR_FETCH;
          end
        end
        SR_FETCH: sr_state_reg <= SR_SEND;
        SR_SEND: begin
          if (S_RREADY) begin
            if (S_RLAST) begin
              sr_state_reg <= SR_IDLE;
            end else begin
              sr_cnt_reg <= sr_cnt_reg + 1'b1; // R16
              sr_addr_reg <= next_addr(sr_addr_reg, sr_size_reg); // R22
              sr_state_reg <= SR_FETCH;
            end
          end
        end
        default: sr_state_reg <= SR_IDLE;
      endcase
    end
  end

  // read port of the local memory
  always_ff @(posedge CLK) begin
    if (mem_re) begin
      rdata_reg <= mem_reg[mem_raddr]; // R15
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_aw_stall;
    M_AWVALID && !M_AWREADY;
  endsequence
  sequence s_w_stall;
    M_WVALID && !M_WREADY;
  endsequence
  sequence s_b_wait;
    S_BVALID && !S_BREADY;
  endsequence
  sequence s_aw_take;
    S_AWVALID && S_AWREADY;
  endsequence

  a_aw_hold: assert property (s_aw_stall |=> M_AWVALID // R1
    && $stable(M_AWADDR) && $stable(M_AWLEN) && $stable(M_AWID))
    else $error("write address changed before accept");
  a_w_hold: assert property (s_w_stall |=> M_WVALID // R2
    && $stable(M_WDATA) && $stable(M_WLAST))
    else $error("write beat changed before accept");
  a_w_advance: assert property ((w_fire && !M_WLAST) |=> // R3
    (wcnt_reg == $past(wcnt_reg) + 1'b1) && mw_state_reg == MW_DATA)
    else $error("write beat count did not advance");
  a_wlast_final: assert property ((w_fire && M_WLAST) |-> // R4
    (wcnt_reg == aw_reg.len) ##1 M_BREADY && !M_WVALID)
    else $error("last beat flag misplaced");
  a_bresp_check: assert property ((M_BVALID && M_BREADY) |=> // R5
    WR_DONE && (WR_ID_ERR == ($past(M_BID) != aw_reg.id)))
    else $error("response id not compared");
  a_ar_ctrl: assert property ((M_ARVALID && !M_ARREADY) |=> M_ARVALID // R7
    && $stable(M_ARADDR) && $stable(M_ARLEN) && M_ARBURST == `BURST_INCR)
    else $error("read address changed before accept");
  a_rlast_idle: assert property ((M_RVALID && M_RREADY && M_RLAST) |=> // R9
    mr_state_reg == MR_IDLE && !M_RREADY)
    else $error("read machine not idle after last beat");
  a_size_gate: assert property (S_AWREADY |-> // R18
    sw_state_reg == SW_IDLE
    && S_AWSIZE inside {`SIZE_2B, `SIZE_4B, `SIZE_8B})
    else $error("unsupported size acknowledged");
  a_b_hold: assert property (s_b_wait |=> S_BVALID && $stable(S_BID)) // R13
    else $error("write response dropped");
  a_bid_match: assert property ((s_aw_take ##1 1'b1) |-> // R23
    sw_id_reg == $past(S_AWID))
    else $error("response id differs from write id");
  a_r_hold: assert property ((S_RVALID && !S_RREADY) |=> S_RVALID // R16
    && $stable(S_RDATA) && $stable(S_RLAST))
    else $error("read beat changed before accept");
  a_rlast_cnt: assert property ((S_RVALID && S_RREADY && S_RLAST) |-> // R17
    sr_cnt_reg == sr_len_reg ##1 !S_RVALID)
    else $error("read last flag misplaced");

endmodule : axi_fabric_master_slave_interface

// *** rtl/axi_fabric_pkg.sv ***
package axi_fabric_pkg;
  `include "axi_fabric_cfg.svh"

  // one burst request: id, start address, beats minus one, size code
  typedef struct packed {
    logic [`AXI_IDW-1:0] id;
    logic [`AXI_AW-1:0] addr;
    logic [`AXI_LENW-1:0] len;
    logic [`AXI_SZW-1:0] size;
  } burst_req_t;

  typedef enum logic [1:0] {
    MW_IDLE = 2'h0, MW_ADDR = 2'h1, MW_DATA = 2'h3, MW_RESP = 2'h2
  } mw_state_t;

  typedef enum logic [1:0] {
    MR_IDLE = 2'h0, MR_ADDR = 2'h1, MR_DATA = 2'h3
  } mr_state_t;

  typedef enum logic [1:0] {
    SW_IDLE = 2'h0, SW_DATA = 2'h1, SW_RESP = 2'h3
  } sw_state_t;

  typedef enum logic [1:0] {
    SR_IDLE = 2'h0, SR_FETCH = 2'h1, SR_SEND = 2'h3
  } sr_state_t;
endpackage : axi_fabric_pkg

// *** test/axi_fabric_master_slave_interface_tb.sv ***
`timescale 1ns/100ps
// ********************************************************************
// bench top
// ********************************************************************
module axi_fabric_master_slave_interface_tb
  import axi_fabric_pkg::*;
;
  // bench-driven inputs
  logic CLK = 0, RST_N = 0, stall = 0, bad_id = 0;
  burst_req_t WR_CMD = '0, RD_CMD = '0;
  logic WR_CMD_VALID = 0, WR_DATA_VALID = 0, RD_CMD_VALID = 0;
  logic [63:0] WR_DATA = '0, S_WDATA = '0;
  logic [3:0] S_AWID = '0, S_ARID = '0, S_ARLEN = '0;
  logic [31:0] S_AWADDR = '0, S_ARADDR = '0;
  logic [2:0] S_AWSIZE = '0, S_ARSIZE = '0;
  logic [7:0] S_WSTRB = '0;
  logic S_AWVALID = 0, S_WLAST = 0, S_WVALID = 0, S_BREADY = 0;
  logic S_ARVALID = 0, S_RREADY = 0;
  // design outputs and far-side wires
  logic WR_CMD_READY, WR_DATA_READY, WR_DONE, WR_ID_ERR, RD_CMD_READY;
  logic RD_DATA_VALID, RD_DATA_LAST, M_AWVALID, M_AWREADY, M_WLAST;
  logic M_WVALID, M_WREADY, M_BVALID, M_BREADY, M_ARVALID, M_ARREADY;
  logic M_RLAST, M_RVALID, M_RREADY, S_AWREADY, S_WREADY, S_BVALID;
  logic S_ARREADY, S_RLAST, S_RVALID;
  logic [1:0] WR_RESP, M_BRESP, M_AWBURST, M_ARBURST, S_BRESP, S_RRESP;
  logic [2:0] M_AWSIZE, M_ARSIZE;
  logic [3:0] M_AWID, M_AWLEN, M_BID, M_ARID, M_ARLEN, S_BID, S_RID;
  logic [31:0] M_AWADDR, M_ARADDR;
  logic [7:0] M_WSTRB;
  logic [63:0] RD_DATA, M_WDATA, M_RDATA, S_RDATA;
  int err_count = 0, checks_done = 0;

  axi_fabric_master_slave_interface dut_u (.*);
  axi_far_slave far_u (.*);

  // 4 ns clock
  initial forever #2 CLK = ~CLK;

  task chk(input string n, input logic [63:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task results;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // bounded wait for a flag seen high at a rising edge
  task automatic hs(ref logic r);
    int i;
    for (i = 0; i < 100; i++) begin
      @(posedge CLK);
      if (r === 1'b1) break;
    end
    if (i == 100) begin
      err_count++;
      results;
    end
  endtask : hs

  // issue a user write command and wait for its completion pulse
  task m_cmd(input burst_req_t c);
    WR_CMD <= c;
    WR_CMD_VALID <= 1;
    hs(WR_CMD_READY);
    WR_CMD_VALID <= 0;
    hs(WR_DONE);
  endtask : m_cmd

  // fill the buffer until it refuses, drain it through a slow far side
  task m_write_long;
    int k;
    WR_DATA_VALID <= 1;
    for (k = 0; k < 9; k++) begin
      WR_DATA <= 64'hA000 + k;
      @(posedge CLK);
      chk("wr_data_ready", WR_DATA_READY, k < 8);
    end
    WR_DATA_VALID <= 0;
    stall <= 1;
    m_cmd('{4'h3, 32'h80, 4'h7, 3'h3});
    chk("id_err", WR_ID_ERR, 0);
    chk("wr_resp", WR_RESP, 0);
    chk("aw_ctrl", {M_AWID, M_AWBURST, M_AWSIZE, M_AWLEN, M_WSTRB},
        21'h6B7FF);
    chk("aw_addr", M_AWADDR, 32'h80);
    for (k = 0; k < 8; k++) begin
      chk("far_mem", far_u.mem[16 + k], 64'hA000 + k);
    end
  endtask : m_write_long

  // single-beat burst answered with a foreign id
  task m_write_bad;
    bad_id <= 1;
    WR_DATA <= 64'h5A;
    WR_DATA_VALID <= 1;
    @(posedge CLK);
    WR_DATA_VALID <= 0;
    m_cmd('{4'h6, 32'h0, 4'h0, 3'h3});
    chk("id_err", WR_ID_ERR, 1);
    chk("far_mem", far_u.mem[0], 64'h5A);
    bad_id <= 0;
  endtask : m_write_bad

  // read the long burst back while the far side stalls
  task m_read;
    int k;
    RD_CMD <= '{4'h2, 32'h80, 4'h7, 3'h3};
    RD_CMD_VALID <= 1;
    hs(RD_CMD_READY);
    RD_CMD_VALID <= 0;
    @(posedge CLK);
    chk("ar_ctrl", {M_ARVALID, M_ARLEN, M_ARBURST}, 7'h5D);
    chk("ar_id_size", {M_ARID, M_ARSIZE, M_ARADDR}, 39'h1300000080);
    for (k = 0; k < 8; k++) begin
      hs(RD_DATA_VALID);
      chk("rd_data", RD_DATA, 64'hA000 + k);
      chk("rd_last", RD_DATA_LAST, k == 7);
    end
    @(posedge CLK);
    chk("rd_idle", {RD_CMD_READY, M_RREADY}, 2'h2);
    stall <= 0;
  endtask : m_read

  // slave burst, late response acceptance, then read back with a stall
  task s_burst;
    int k;
    S_AWID <= 4'h5;
    S_AWADDR <= 32'h40;
    S_AWSIZE <= 3'h3;
    S_AWVALID <= 1;
    hs(S_AWREADY);
    S_AWVALID <= 0;
    S_WSTRB <= 8'hFF;
    for (k = 0; k < 3; k++) begin
      S_WDATA <= 64'hC0 + k;
      S_WLAST <= k == 2;
      S_WVALID <= 1;
      hs(S_WREADY);
    end
    S_WVALID <= 0;
    repeat (3) @(posedge CLK);
    chk("bresp", {S_BVALID, S_BID, S_BRESP}, 7'h54);
    S_BREADY <= 1;
    hs(S_BVALID);
    S_BREADY <= 0;
    S_ARID <= 4'h9;
    S_ARADDR <= 32'h40;
    S_ARLEN <= 4'h2;
    S_ARSIZE <= 3'h3;
    S_ARVALID <= 1;
    hs(S_ARREADY);
    S_ARVALID <= 0;
    repeat (4) @(posedge CLK);
    chk("rvalid_held", S_RVALID, 1);
    S_RREADY <= 1;
    for (k = 0; k < 3; k++) begin
      hs(S_RVALID);
      chk("s_rdata", S_RDATA, 64'hC0 + k);
      chk("rid_last", {S_RID, S_RLAST}, k == 2 ? 5'h13 : 5'h12);
      chk("s_rresp", S_RRESP, 0);
    end
    S_RREADY <= 0;
  endtask : s_burst

  // only the two, four and eight byte size codes are acknowledged
  task s_sizes;
    int k;
    for (k = 0; k < 8; k++) begin
      S_AWSIZE <= k[2:0];
      S_ARSIZE <= k[2:0];
      repeat (2) @(posedge CLK);
      chk("awready_size", S_AWREADY, k inside {[1:3]});
      chk("arready_size", S_ARREADY, k inside {[1:3]});
    end
  endtask : s_sizes

  // main sequence
  initial begin
    repeat (2) @(posedge CLK);
    chk("reset_quiet", {M_AWVALID, M_WVALID, M_BREADY, M_ARVALID,
        M_RREADY, S_WREADY, S_BVALID, S_RVALID}, 0);
    RST_N <= 1;
    m_write_long;
    m_write_bad;
    m_read;
    s_burst;
    s_sizes;
    results;
  end
endmodule : axi_fabric_master_slave_interface_tb

// *** test/axi_far_slave.sv ***
`timescale 1ns/100ps
// ********************************************************************
// far-side slave: memory behind the master channels
// ********************************************************************
module axi_far_slave (
  // clock, reset and test knobs
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic stall,
  input wire logic bad_id,
  // write channels
  input wire logic [3:0] M_AWID,
  input wire logic [31:0] M_AWADDR,
  input wire logic M_AWVALID,
  output logic M_AWREADY,
  input wire logic [63:0] M_WDATA,
  input wire logic M_WLAST,
  input wire logic M_WVALID,
  output logic M_WREADY,
  output logic [3:0] M_BID,
  output logic [1:0] M_BRESP,
  output logic M_BVALID,
  input wire logic M_BREADY,
  // read channels
  input wire logic [31:0] M_ARADDR,
  input wire logic [3:0] M_ARLEN,
  input wire logic M_ARVALID,
  output logic M_ARREADY,
  output logic [63:0] M_RDATA,
  output logic M_RLAST,
  output logic M_RVALID,
  input wire logic M_RREADY
);
  logic [63:0] mem [256];
  logic [7:0] wa, ra;
  logic [3:0] rn;
  logic [1:0] cnt;
  logic rb, slow;

  // when stalling, answer only one cycle in four
  assign slow = stall && cnt != 2'h3;

  // defined levels before the first clock edge
  initial begin
    {M_BID, M_BRESP, M_RDATA, M_RLAST} = '0;
    {M_AWREADY, M_WREADY, M_BVALID, M_ARREADY, M_RVALID} = '0;
  end

  // every ready pulses once per request, so each write beat costs at least two cycles
  always @(posedge CLK) begin
    cnt <= cnt + 2'h1;
    if (!RST_N) begin
      {M_AWREADY, M_WREADY, M_BVALID, M_ARREADY, M_RVALID} <= '0;
      {rb, cnt} <= '0;
    end else begin
      M_AWREADY <= M_AWVALID && !M_AWREADY && !slow;
      M_WREADY <= M_WVALID && !M_WREADY && !slow;
      M_ARREADY <= M_ARVALID && !M_ARREADY && !slow;
      if (M_AWVALID && M_AWREADY) begin
        wa <= M_AWADDR[10:3];
        M_BID <= M_AWID ^ {3'h0, bad_id};
      end
      if (M_WVALID && M_WREADY) begin
        mem[wa] <= M_WDATA;
        wa <= wa + 8'h1;
        M_BVALID <= M_WLAST;
      end else if (M_BREADY) begin
        M_BVALID <= 1'b0;
      end
      if (M_ARVALID && M_ARREADY) begin
        ra <= M_ARADDR[10:3];
        rn <= M_ARLEN;
        rb <= 1'b1;
      end
      if (rb && !(M_RVALID && !M_RREADY) && !slow) begin
        M_RVALID <= 1'b1;
        M_RDATA <= mem[ra];
        M_RLAST <= rn == 4'h0;
        ra <= ra + 8'h1;
        rn <= rn - 4'h1;
        rb <= rn != 4'h0;
      end else if (M_RVALID && M_RREADY) begin
        M_RVALID <= 1'b0;
        M_RDATA <= ~M_RDATA; // a released bus shows no stale beat
      end
    end
  end
endmodule : axi_far_slave
